// File: hdl/crcu_pkg.sv
// ****************************************************************
// Constants, types and checksum functions
// ****************************************************************
package crcu_pkg;

    localparam logic [31:0] CRCU_POLY = 32'h04C11DB7;
    localparam logic [31:0] CRCU_INIT = 32'hFFFFFFFF;
    localparam logic [7:0] CRCU_OFF_RESULT = 8'h00;
    localparam logic [7:0] CRCU_OFF_SCRATCH = 8'h04;
    localparam logic [7:0] CRCU_OFF_CONTROL = 8'h08;
    localparam logic [7:0] CRCU_SCRATCH_RST = 8'h00;
    localparam logic CRCU_REINIT_RST = 1'b0;
    localparam int CRCU_REINIT_BIT = 0;
    localparam logic [1:0] CRCU_LAST_STEP = 2'h3;
    localparam logic [1:0] CRCU_FIRST_STEP = 2'h0;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
        logic [31:0] wdata;
    } crcu_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
    } crcu_rsp_t;

    typedef enum logic {
        CRCU_IDLE,
        CRCU_CALC
    } crcu_phase_t;

    typedef struct packed {
        crcu_phase_t phase;
        logic [1:0] step;
        logic [31:0] word;
        logic [31:0] crc;
        logic [7:0] scratch;
        logic reinit;
        crcu_rsp_t rsp;
    } crcu_state_t;

    // Folds one byte, most significant bit first
    function automatic logic [31:0] crcu_fold_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = (r[31] ^ d[i]) ? ({r[30:0], 1'b0} ^ CRCU_POLY) : {r[30:0], 1'b0};
        end
        return r;
    endfunction : crcu_fold_byte

    // Folds one word, top byte first
    function automatic logic [31:0] crcu_fold_word(input logic [31:0] c, input logic [31:0] w);
        logic [31:0] r;
        r = c;
        for (int k = 0; k < 4; k++) begin
            r = crcu_fold_byte(r, w[31 - 8 * k -: 8]);
        end
        return r;
    endfunction : crcu_fold_word

endpackage : crcu_pkg

// File: hdl/crcu_unit.sv
// Notes on behaviour
// [R1] The checksum uses the fixed generator polynomial 0x4C11DB7 and nothing can change it.
// [R2] One data register takes 32-bit input words and reads back the 32-bit checksum.
// [R3] The updated checksum is ready 4 clock cycles after a word is written.
// [R4] A written word is held in a 32-bit buffer so the write completes at once; a word written during a calculation is stalled until it ends.
// [R5] Each new word is folded into the checksum left by the previous one unless reinitialised.
// [R6] A write at offset 0x00 feeds the calculation and never overwrites the checksum itself.
// [R7] A read at offset 0x00 returns the latest checksum, never the raw written word.
// [R8] Reset gives a checksum of all ones and zero scratch and control registers.
// [R9] Writing one to control bit 0 loads all ones into the checksum and the bit clears itself.
// [R10] Reinitialising leaves the scratch byte alone.
// [R11] Bits 7:0 at offset 0x04 are a scratch byte that reads back as written and never affects the checksum.
// [R12] Software uses only full 32-bit word accesses.
// [R13] Software keeps reserved bits at their reset value.
// [R14] Words are processed most significant bit first, unreflected, with no final inversion.
// [R15] A word or reinit arriving during a calculation is stalled so nothing is lost or reordered.
`timescale 1ns/10ps
`default_nettype none

module crcu_unit (
    input wire logic clk,
    input wire logic rst_b,
    input wire crcu_pkg::crcu_req_t req,
    output var crcu_pkg::crcu_rsp_t rsp
);

    // ****************************************************************
    // State
    // ****************************************************************
    crcu_pkg::crcu_state_t state_ff;
    crcu_pkg::crcu_state_t nxt_state;
    logic take;
    logic stall;
    logic calc;

    // ****************************************************************
    // Access decode
    // ****************************************************************
    // Matches a request to one offset and one direction
    function automatic logic is_access(input crcu_pkg::crcu_req_t r, input logic [7:0] off,
        input logic wr);
        return (r.addr == off) && (r.write == wr);
    endfunction : is_access

    assign calc = (state_ff.phase == crcu_pkg::CRCU_CALC);
    assign take = req.valid && !state_ff.rsp.ack;
    assign stall = take && calc && ((req.addr == crcu_pkg::CRCU_OFF_RESULT)
        || (req.write && (req.addr == crcu_pkg::CRCU_OFF_CONTROL))); // R15

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        nxt_state = state_ff;
        nxt_state.rsp.ack = 1'b0;
        nxt_state.reinit = 1'b0; // R9
        if (calc) begin
            nxt_state.crc = crcu_pkg::crcu_fold_byte(state_ff.crc, state_ff.word[31:24]); // R1 R5 R14
            nxt_state.word = {state_ff.word[23:0], 8'h00};
            nxt_state.step = state_ff.step + 2'h1;
            if (state_ff.step == crcu_pkg::CRCU_LAST_STEP) begin
                nxt_state.phase = crcu_pkg::CRCU_IDLE; // R3
            end
        end
        if (take && !stall) begin
            nxt_state.rsp.ack = 1'b1;
            nxt_state.rsp.rdata = 32'h00000000;
            unique case (req.addr)
                crcu_pkg::CRCU_OFF_RESULT: begin
                    if (req.write) begin
                        nxt_state.word = req.wdata; // R4 R6
                        nxt_state.step = crcu_pkg::CRCU_FIRST_STEP;
                        nxt_state.phase = crcu_pkg::CRCU_CALC;
                    end else begin
                        nxt_state.rsp.rdata = state_ff.crc; // R2 R7
                    end
                end
                crcu_pkg::CRCU_OFF_SCRATCH: begin
                    if (req.write) begin
                        nxt_state.scratch = req.wdata[7:0]; // R11
                    end else begin
                        nxt_state.rsp.rdata = {24'h000000, state_ff.scratch}; // R11
                    end
                end
                crcu_pkg::CRCU_OFF_CONTROL: begin
                    if (req.write) begin
                        nxt_state.reinit = req.wdata[crcu_pkg::CRCU_REINIT_BIT];
                        if (req.wdata[crcu_pkg::CRCU_REINIT_BIT]) begin
                            nxt_state.crc = crcu_pkg::CRCU_INIT; // R9 R10
                        end
                    end else begin
                        nxt_state.rsp.rdata = {31'h00000000, state_ff.reinit};
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff.phase <= crcu_pkg::CRCU_IDLE;
            state_ff.step <= crcu_pkg::CRCU_FIRST_STEP;
            state_ff.word <= 32'h00000000;
            state_ff.crc <= crcu_pkg::CRCU_INIT; // R8
            state_ff.scratch <= crcu_pkg::CRCU_SCRATCH_RST; // R8
            state_ff.reinit <= crcu_pkg::CRCU_REINIT_RST; // R8
            state_ff.rsp <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign rsp = state_ff.rsp;

    // ****************************************************************
    // Checks
    // ****************************************************************
    logic acc;
    logic acc_dw;
    logic acc_dr;
    logic acc_sw;
    logic acc_sr;
    logic acc_cw;
    logic acc_cr;
    assign acc = take && !stall;
    assign acc_dw = acc && is_access(req, crcu_pkg::CRCU_OFF_RESULT, 1'b1);
    assign acc_dr = acc && is_access(req, crcu_pkg::CRCU_OFF_RESULT, 1'b0);
    assign acc_sw = acc && is_access(req, crcu_pkg::CRCU_OFF_SCRATCH, 1'b1);
    assign acc_sr = acc && is_access(req, crcu_pkg::CRCU_OFF_SCRATCH, 1'b0);
    assign acc_cw = acc && is_access(req, crcu_pkg::CRCU_OFF_CONTROL, 1'b1);
    assign acc_cr = acc && is_access(req, crcu_pkg::CRCU_OFF_CONTROL, 1'b0);

    crc_latency_a: assert property (@(posedge clk) disable iff (!rst_b) // R3
        acc_dw |-> ##5 (state_ff.crc == crcu_pkg::crcu_fold_word($past(state_ff.crc, 5),
        $past(req.wdata, 5))) && !calc)
        else $error("checksum not ready four cycles after write");
    word_buffer_a: assert property (@(posedge clk) disable iff (!rst_b) // R4 R6
        acc_dw |=> calc && rsp.ack && (state_ff.word == $past(req.wdata)))
        else $error("written word not buffered");
    read_result_a: assert property (@(posedge clk) disable iff (!rst_b) // R7
        (acc && !req.write && (req.addr == crcu_pkg::CRCU_OFF_RESULT))
        |=> rsp.ack && (rsp.rdata == $past(state_ff.crc)))
        else $error("result read wrong");
    reinit_load_a: assert property (@(posedge clk) disable iff (!rst_b) // R9
        (acc && req.write && (req.addr == crcu_pkg::CRCU_OFF_CONTROL) && req.wdata[0])
        |=> (state_ff.crc == crcu_pkg::CRCU_INIT) && state_ff.reinit ##1 !state_ff.reinit)
        else $error("reinit failed");
    scratch_keep_a: assert property (@(posedge clk) disable iff (!rst_b) // R10
        (acc && req.addr == crcu_pkg::CRCU_OFF_CONTROL) |=> $stable(state_ff.scratch))
        else $error("scratch changed by control");
    scratch_write_a: assert property (@(posedge clk) disable iff (!rst_b) // R11
        (acc && req.write && (req.addr == crcu_pkg::CRCU_OFF_SCRATCH) && !calc)
        |=> (state_ff.scratch == $past(req.wdata[7:0])) && $stable(state_ff.crc))
        else $error("scratch write wrong");
    reset_value_a: assert property (@(posedge clk) // R8
        !rst_b |-> (state_ff.crc == crcu_pkg::CRCU_INIT) && (state_ff.scratch == 8'h00)
        && !state_ff.reinit)
        else $error("reset values wrong");
    stall_busy_a: assert property (@(posedge clk) disable iff (!rst_b) // R15
        stall |=> !rsp.ack && $stable(state_ff.scratch))
        else $error("busy access not stalled");
    ack_pulse_a: assert property (@(posedge clk) disable iff (!rst_b) // R2
        rsp.ack |=> !rsp.ack)
        else $error("ack longer than one cycle");
    calc_length_a: assert property (@(posedge clk) disable iff (!rst_b) // R3
        acc_dw |=> calc [*4] ##1 !calc)
        else $error("calculation length wrong");
    step_idle_a: assert property (@(posedge clk) disable iff (!rst_b) // R3
        !calc |-> (state_ff.step == crcu_pkg::CRCU_FIRST_STEP))
        else $error("step counter not rewound");
    idle_take_a: assert property (@(posedge clk) disable iff (!rst_b) // R15
        (acc_dw || acc_dr || acc_cw) |-> !calc)
        else $error("access taken during calculation");
    result_kept_a: assert property (@(posedge clk) disable iff (!rst_b) // R6
        acc_dw |=> $stable(state_ff.crc))
        else $error("write overwrote checksum");
    crc_quiet_a: assert property (@(posedge clk) disable iff (!rst_b) // R5
        (!calc && !acc_cw) |=> $stable(state_ff.crc))
        else $error("checksum changed while idle");
    ack_answer_a: assert property (@(posedge clk) disable iff (!rst_b) // R4
        acc |=> rsp.ack)
        else $error("accepted access not answered");
    ack_only_a: assert property (@(posedge clk) disable iff (!rst_b) // R15
        !acc |=> !rsp.ack)
        else $error("ack without accepted access");
    scratch_only_a: assert property (@(posedge clk) disable iff (!rst_b) // R10 R11
        !acc_sw |=> $stable(state_ff.scratch))
        else $error("scratch changed without a write");
    scratch_read_a: assert property (@(posedge clk) disable iff (!rst_b) // R11
        acc_sr |=> rsp.ack && (rsp.rdata == {24'h000000, $past(state_ff.scratch)}))
        else $error("scratch read wrong");
    write_rdata_a: assert property (@(posedge clk) disable iff (!rst_b) // R7
        (acc && req.write) |=> rsp.ack && (rsp.rdata == 32'h00000000))
        else $error("write returned data");
    control_read_a: assert property (@(posedge clk) disable iff (!rst_b) // R9
        acc_cr |=> rsp.ack && (rsp.rdata == {31'h00000000, $past(state_ff.reinit)}))
        else $error("control read wrong");
    reinit_seed_a: assert property (@(posedge clk) disable iff (!rst_b) // R9
        state_ff.reinit |-> (state_ff.crc == crcu_pkg::CRCU_INIT))
        else $error("reinit without seed");
    unmapped_a: assert property (@(posedge clk) disable iff (!rst_b) // R2
        (acc && !acc_dw && !acc_dr && !acc_sw && !acc_sr && !acc_cw && !acc_cr)
        |=> rsp.ack && (rsp.rdata == 32'h00000000) && $stable(state_ff.scratch))
        else $error("unmapped access had an effect");

    // ****************************************************************
    // Coverage
    // ****************************************************************
    data_write_c: cover property (@(posedge clk) disable iff (!rst_b) acc_dw);
    scratch_busy_c: cover property (@(posedge clk) disable iff (!rst_b) acc_sw && calc);
    stall_seen_c: cover property (@(posedge clk) disable iff (!rst_b) stall);
    reinit_seen_c: cover property (@(posedge clk) disable iff (!rst_b) state_ff.reinit);
    back_to_back_c: cover property (@(posedge clk) disable iff (!rst_b)
        acc_dw ##[1:8] acc_dw);

endmodule : crcu_unit

`default_nettype wire

// File: tb/crcu_unit_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// ************************************************
// Self-checking bench for the checksum unit
// ************************************************
module crcu_unit_tb_top;
    logic clk;
    logic rst_b;
    crcu_pkg::crcu_req_t req;
    crcu_pkg::crcu_rsp_t rsp;
    int n_errors;
    int total_checks;
    int seed;
    int last_wait;
    logic [31:0] exp_crc;
    logic [31:0] rd;
    logic [31:0] w;
    logic [7:0] sb;

    crcu_unit u_dut (.clk(clk), .rst_b(rst_b), .req(req), .rsp(rsp));

    always #12.5 clk = ~clk;

    // Bitwise reference, most significant bit first
    function automatic logic [31:0] ref_fold(input logic [31:0] c, input logic [31:0] d);
        for (int i = 31; i >= 0; i--) begin
            c = (c[31] ^ d[i]) ? ({c[30:0], 1'b0} ^ crcu_pkg::CRCU_POLY) : {c[30:0], 1'b0};
        end
        return c;
    endfunction : ref_fold

    task report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // One register access, held until the acknowledge
    task bus(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
             output logic [31:0] rdata);
        @(posedge clk);
        #2;
        req = '{valid: 1'b1, write: wr, addr: addr, wdata: wdata};
        last_wait = 0;
        do begin
            @(posedge clk);
            #2;
            last_wait++;
        end while (rsp.ack !== 1'b1 && last_wait < 20);
        rdata = rsp.rdata;
        req.valid = 1'b0;
        if (last_wait >= 20) begin
            n_errors++;
            report_and_stop();
        end
    endtask : bus

    initial begin
        clk = 1'b0;
        rst_b = 1'b1;
        req = '0;
        n_errors = 0;
        total_checks = 0;
        seed = 76419;
        sb = 8'h00;
        #1;
        rst_b = 1'b0;
        repeat (16) @(posedge clk);
        #2;
        rst_b = 1'b1;
        bus(1'b0, 8'h00, 32'h0, rd);
        chk("result reset", rd, 32'hFFFFFFFF);
        bus(1'b0, 8'h04, 32'h0, rd);
        chk("scratch reset", rd, 32'h00000000);
        bus(1'b0, 8'h08, 32'h0, rd);
        chk("control reset", rd, 32'h00000000);
        $display("test reset done");
        exp_crc = crcu_pkg::CRCU_INIT;
        for (int k = 0; k < 40; k++) begin
            w = (k == 0) ? 32'h00000000 : (k == 1) ? 32'hFFFFFFFF : $random(seed);
            bus(1'b1, 8'h00, w, rd);
            exp_crc = ref_fold(exp_crc, w);
            if (k % 5 == 2) begin
                sb = 8'($random(seed));
                bus(1'b1, 8'h04, {24'h000000, sb}, rd);
                bus(1'b0, 8'h04, 32'h0, rd);
                chk("scratch", rd, {24'h000000, sb});
            end
            if (k % 3 == 0) begin
                bus(1'b0, 8'h00, 32'h0, rd);
                chk("read wait", 32'(last_wait <= 4), 32'h1);
                chk("checksum", rd, exp_crc);
            end
        end
        bus(1'b0, 8'h00, 32'h0, rd);
        chk("checksum after burst", rd, exp_crc);
        $display("test stream done");
        bus(1'b1, 8'h08, 32'h1, rd);
        bus(1'b0, 8'h00, 32'h0, rd);
        chk("reinit result", rd, 32'hFFFFFFFF);
        bus(1'b0, 8'h08, 32'h0, rd);
        chk("control clear", rd, 32'h00000000);
        bus(1'b0, 8'h04, 32'h0, rd);
        chk("scratch kept", rd, {24'h000000, sb});
        bus(1'b1, 8'h00, 32'h12345678, rd);
        bus(1'b0, 8'h00, 32'h0, rd);
        chk("fold after reinit", rd, ref_fold(32'hFFFFFFFF, 32'h12345678));
        bus(1'b1, 8'h08, 32'h0, rd);
        bus(1'b0, 8'h00, 32'h0, rd);
        chk("control zero write", rd, ref_fold(32'hFFFFFFFF, 32'h12345678));
        $display("test reinit done");
        bus(1'b0, 8'h0C, 32'h0, rd);
        chk("unmapped read", rd, 32'h00000000);
        $display("test unmapped done");
        bus(1'b1, 8'h04, 32'h000000A5, rd);
        w = $random(seed);
        bus(1'b1, 8'h00, w, rd);
        rst_b = 1'b0;
        repeat (2) @(posedge clk);
        #2;
        rst_b = 1'b1;
        bus(1'b0, 8'h00, 32'h0, rd);
        chk("result after reset", rd, 32'hFFFFFFFF);
        bus(1'b0, 8'h04, 32'h0, rd);
        chk("scratch after reset", rd, 32'h00000000);
        $display("test midrun reset done");
        report_and_stop();
    end
endmodule : crcu_unit_tb_top
`default_nettype wire
